/* mcvr_pkg.sv */
// Shared constants for the MAC configuration, VLAN and misc register group.
// Assumes both ends, the checker and the bench import this package whole.
package mcvr_pkg;

    // Device register offsets on the 5-bit register bus.
    localparam logic [4:0] MCVR_OFS_JAM_STATUS = 5'h17; // Jam limit on write, device status on read.
    localparam logic [4:0] MCVR_OFS_MAC_CONFIG = 5'h1B;
    localparam logic [4:0] MCVR_OFS_VLAN_LO    = 5'h1C; // Tx end page status on read.
    localparam logic [4:0] MCVR_OFS_VLAN_HI    = 5'h1D;
    localparam logic [4:0] MCVR_OFS_BYTE_ORDER = 5'h1E;
    localparam logic [4:0] MCVR_OFS_WAKE       = 5'h1F; // Soft reset trigger on read.

    // Field positions of the MAC configuration register, then the queue full, endian and wake bits.
    localparam int MCVR_MC_DUPLEX  = 0;
    localparam int MCVR_MC_BPLEAK  = 1;
    localparam int MCVR_MC_B2B     = 2;
    localparam int MCVR_MC_MEDIA   = 3;
    localparam int MCVR_MC_VLAN    = 4;
    localparam int MCVR_MC_CAPTURE = 5;
    localparam int MCVR_MC_SHORT   = 6;
    localparam int MCVR_MC_ZERO    = 7;
    localparam int MCVR_QFULL_BIT  = 7;
    localparam int MCVR_ENDIAN_BIT = 7;
    localparam int MCVR_WAKE_BIT   = 0;

    // Reset values.
    localparam logic [7:0] MCVR_MAC_CONFIG_RST = 8'h00;
    localparam logic [5:0] MCVR_JAM_LIMIT_RST  = 6'h19;
    localparam logic [6:0] MCVR_END_PAGE_RST   = 7'h00;
    localparam logic [7:0] MCVR_BYTE_ORDER_RST = 8'h00;

    // Frame and back-off constants.
    localparam logic [15:0] MCVR_VLAN_TPID       = 16'h8100;
    localparam logic [9:0]  MCVR_CAPTURE_FIRST   = 10'h002;
    localparam logic [9:0]  MCVR_CAPTURE_SECOND  = 10'h000;
    localparam logic [9:0]  MCVR_SHORT_MASK      = 10'h003;
    localparam logic [3:0]  MCVR_BACKOFF_LIMIT   = 4'hA;

    // Host controller register offsets and fields.
    localparam logic [2:0] MCVR_H_ADDR   = 3'h0;
    localparam logic [2:0] MCVR_H_WDATA  = 3'h1;
    localparam logic [2:0] MCVR_H_CMD    = 3'h2;
    localparam logic [2:0] MCVR_H_RDATA  = 3'h3;
    localparam logic [2:0] MCVR_H_STATUS = 3'h4;
    localparam logic [2:0] MCVR_H_MASK   = 3'h5;
    localparam int MCVR_CMD_WRITE = 0;
    localparam int MCVR_CMD_READ  = 1;
    localparam int MCVR_CMD_TXQ   = 2;
    localparam int MCVR_CMD_WAKE  = 3;
    localparam int MCVR_EV_DONE   = 0;
    localparam int MCVR_EV_FULL   = 1;
    localparam int MCVR_EV_GRANT  = 2;
    localparam logic [7:0] MCVR_WAKE_VALUE = 8'h01;

endpackage : mcvr_pkg

/* mcvr_bus_if.sv */
// Register bus between the host controller and the device register group.
// Assumes one shared clock; read data stand in the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
interface mcvr_bus_if;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;

    modport device (input addr, input wdata, input wr, input rd, output rdata);
    modport host   (output addr, output wdata, output wr, output rd, input rdata);
endinterface : mcvr_bus_if
`default_nettype wire

/* mcvr_vlan_check.sv */
// VLAN acceptance decision for one received frame header.
// Assumes the tag fields are stable while the check strobe is high.
`timescale 1ns/1ps
`default_nettype none
module mcvr_vlan_check
    import mcvr_pkg::*;
(
    // Configuration.
    input  wire logic        filter_en,
    input  wire logic [11:0] prog_vid,
    // Frame header fields.
    input  wire logic        tag_present,
    input  wire logic [15:0] tpid,
    input  wire logic [11:0] vid,
    // Decision.
    output logic             accept
);

    // Untagged frames are dropped while filtering; a null VID always passes.
    always_comb
    begin
        if (!filter_en)
            accept = 1'b1;
        else if (!tag_present)
            accept = 1'b0;
        else
            accept = (tpid != MCVR_VLAN_TPID) || (vid == 12'h000) || (vid == prog_vid);
    end

endmodule : mcvr_vlan_check
`default_nettype wire

/* mcvr_device.sv */
// Device end: MAC configuration, VLAN, transmit page status and misc registers.
// Assumes the host end drives the register bus with one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
module mcvr_device
    import mcvr_pkg::*;
(
    // Clock and reset.
    input  wire logic        CLOCK,
    input  wire logic        SYS_RST,
    // Register bus.
    mcvr_bus_if.device       bus,
    // Duplex and media.
    input  wire logic        TX_CFG_FULL_DUPLEX,
    input  wire logic        PHY_FULL_DUPLEX,
    output logic             MAC_FULL_DUPLEX,
    output logic             EXT_MII_SELECT,
    output logic             BACK_TO_BACK_EN,
    // Back-pressure.
    input  wire logic [5:0]  CONSEC_COLLISIONS,
    output logic             BP_LEAK_ALLOW,
    // Back-off.
    input  wire logic        BACKOFF_REQ,
    input  wire logic [3:0]  COLLISION_NUM,
    input  wire logic [9:0]  BACKOFF_RANDOM,
    output logic [9:0]       BACKOFF_SLOTS,
    output logic             BACKOFF_VALID,
    // VLAN filter.
    input  wire logic        FRAME_CHECK,
    input  wire logic        FRAME_TAGGED,
    input  wire logic [15:0] FRAME_TPID,
    input  wire logic [11:0] FRAME_VID,
    output logic             FRAME_ACCEPT,
    output logic             FRAME_VALID,
    output logic [2:0]       FRAME_PRIORITY,
    output logic             FRAME_CFI,
    // Transmit status.
    input  wire logic        TX_QUEUE_FULL,
    input  wire logic        TX_DONE_CLEAN,
    input  wire logic [6:0]  TX_END_PAGE,
    input  wire logic        STOP_CMD,
    // Power and reset.
    input  wire logic        DEVICE_AWAKE,
    output logic             WAKE_REQUEST,
    output logic             BIG_ENDIAN,
    output logic             SOFT_RESET
);

    typedef struct packed {
        logic [7:0]  mac_config;
        logic [5:0]  jam_limit;
        logic [11:0] vlan_id;
        logic [2:0]  frame_priority;
        logic        cfi;
        logic [7:0]  byte_order;
        logic        host_wake_bit;
        logic [6:0]  end_page;
        logic [7:0]  rdata;
        logic        soft_reset;
        logic [9:0]  backoff;
        logic        backoff_valid;
        logic        frame_accept;
        logic        frame_valid;
        logic        bp_leak;
        logic        full_duplex;
    } mcvr_dev_state_t;

    mcvr_dev_state_t st_r;
    mcvr_dev_state_t st_nxt;
    logic            vlan_ok;

    // Normal truncated exponential back-off: range grows with collisions up to a cap.
    function automatic logic [9:0] mcvr_backoff_mask(input logic [3:0] n);
        logic [3:0] k;
        k = (n > MCVR_BACKOFF_LIMIT) ? MCVR_BACKOFF_LIMIT : n;
        return 10'((11'h001 << k) - 11'h001);
    endfunction

    // Full duplex as the MAC really runs it; with the internal PHY selected its result wins.
    function automatic logic mcvr_duplex(input logic [7:0] cfg, input logic tcr_fd, input logic phy_fd);
        if (!cfg[MCVR_MC_MEDIA])
            return phy_fd;
        return cfg[MCVR_MC_DUPLEX] | tcr_fd;
    endfunction

    mcvr_vlan_check u_vlan (
        .filter_en   (st_r.mac_config[MCVR_MC_VLAN]),
        .prog_vid    (st_r.vlan_id),
        .tag_present (FRAME_TAGGED),
        .tpid        (FRAME_TPID),
        .vid         (FRAME_VID),
        .accept      (vlan_ok)
    );

    // Next-state logic for the whole register group.
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.soft_reset    = 1'b0;
        st_nxt.backoff_valid = 1'b0;
        st_nxt.frame_valid   = 1'b0;
        st_nxt.rdata         = 8'h00;

        // Register writes.
        if (bus.wr)
        begin
            case (bus.addr)
                MCVR_OFS_JAM_STATUS: st_nxt.jam_limit = bus.wdata[5:0];
                MCVR_OFS_MAC_CONFIG: st_nxt.mac_config = bus.wdata;
                MCVR_OFS_VLAN_LO:    st_nxt.vlan_id[7:0] = bus.wdata;
                MCVR_OFS_VLAN_HI:
                begin
                    st_nxt.frame_priority = bus.wdata[7:5];
                    st_nxt.cfi            = bus.wdata[4];
                    st_nxt.vlan_id[11:8]  = bus.wdata[3:0];
                end
                MCVR_OFS_BYTE_ORDER: st_nxt.byte_order = bus.wdata;
                MCVR_OFS_WAKE:       st_nxt.host_wake_bit = bus.wdata[MCVR_WAKE_BIT];
                default: ;
            endcase
        end

        // The self-clear is applied after a same-cycle write so a wake already done is not re-armed.
        if (DEVICE_AWAKE)
            st_nxt.host_wake_bit = 1'b0;

        // Register reads; data stand in the next cycle only.
        if (bus.rd)
        begin
            case (bus.addr)
                MCVR_OFS_JAM_STATUS:
                    st_nxt.rdata[MCVR_ENDIAN_BIT] = (st_r.byte_order != 8'h00);
                MCVR_OFS_MAC_CONFIG:
                begin
                    st_nxt.rdata = st_r.mac_config;
                    st_nxt.rdata[MCVR_MC_DUPLEX] = st_r.full_duplex;
                end
                MCVR_OFS_VLAN_LO:
                    st_nxt.rdata = {TX_QUEUE_FULL, st_r.end_page};
                MCVR_OFS_WAKE:
                    st_nxt.soft_reset = 1'b1;
                default: ;
            endcase
        end

        // Current transmit end page; a stop clears it ahead of a completion.
        if (STOP_CMD)
            st_nxt.end_page = MCVR_END_PAGE_RST;
        else if (TX_DONE_CLEAN)
            st_nxt.end_page = TX_END_PAGE;

        st_nxt.full_duplex = mcvr_duplex(st_r.mac_config, TX_CFG_FULL_DUPLEX, PHY_FULL_DUPLEX);

        // Leak only when allowed and the jam limit has been reached.
        st_nxt.bp_leak = !st_r.mac_config[MCVR_MC_BPLEAK] && (CONSEC_COLLISIONS >= st_r.jam_limit);

        // Back-off selection, test modes first.
        if (BACKOFF_REQ)
        begin
            st_nxt.backoff_valid = 1'b1;
            if (st_r.mac_config[MCVR_MC_ZERO])
                st_nxt.backoff = 10'h000;
            else if (st_r.mac_config[MCVR_MC_CAPTURE] && COLLISION_NUM == 4'h1)
                st_nxt.backoff = MCVR_CAPTURE_FIRST;
            else if (st_r.mac_config[MCVR_MC_CAPTURE] && COLLISION_NUM == 4'h2)
                st_nxt.backoff = MCVR_CAPTURE_SECOND;
            else if (st_r.mac_config[MCVR_MC_SHORT])
                st_nxt.backoff = BACKOFF_RANDOM & MCVR_SHORT_MASK;
            else
                st_nxt.backoff = BACKOFF_RANDOM & mcvr_backoff_mask(COLLISION_NUM);
        end

        // Frame filter decision is held until the next check.
        if (FRAME_CHECK)
        begin
            st_nxt.frame_valid  = 1'b1;
            st_nxt.frame_accept = vlan_ok;
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            st_r                <= '0;
            st_r.mac_config     <= MCVR_MAC_CONFIG_RST;
            st_r.jam_limit      <= MCVR_JAM_LIMIT_RST;
            st_r.byte_order     <= MCVR_BYTE_ORDER_RST;
            st_r.end_page       <= MCVR_END_PAGE_RST;
            st_r.frame_accept   <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register.
    assign bus.rdata       = st_r.rdata;
    assign MAC_FULL_DUPLEX = st_r.full_duplex;
    assign EXT_MII_SELECT  = st_r.mac_config[MCVR_MC_MEDIA];
    assign BACK_TO_BACK_EN = st_r.mac_config[MCVR_MC_B2B];
    assign BP_LEAK_ALLOW   = st_r.bp_leak;
    assign BACKOFF_SLOTS   = st_r.backoff;
    assign BACKOFF_VALID   = st_r.backoff_valid;
    assign FRAME_ACCEPT    = st_r.frame_accept;
    assign FRAME_VALID     = st_r.frame_valid;
    assign FRAME_PRIORITY  = st_r.frame_priority;
    assign FRAME_CFI       = st_r.cfi;
    assign WAKE_REQUEST    = st_r.host_wake_bit;
    assign BIG_ENDIAN      = (st_r.byte_order != 8'h00);
    assign SOFT_RESET      = st_r.soft_reset;

endmodule : mcvr_device
`default_nettype wire

/* mcvr_host.sv */
// Host end: turns software commands into single register bus accesses.
// Assumes the device answers every read in the cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module mcvr_host
    import mcvr_pkg::*;
(
    // Clock and reset.
    input  wire logic       CLOCK,
    input  wire logic       SYS_RST,
    // Software port.
    input  wire logic [2:0] SW_ADDR,
    input  wire logic [7:0] SW_WDATA,
    input  wire logic       SW_WR,
    input  wire logic       SW_RD,
    output logic [7:0]      SW_RDATA,
    output logic            IRQ,
    output logic            TX_QUEUE_GRANT,
    // Register bus.
    mcvr_bus_if.host        bus
);

    typedef enum logic [2:0] {
        MCVR_IDLE    = 3'b001,
        MCVR_ISSUE   = 3'b010,
        MCVR_CAPTURE = 3'b100
    } mcvr_host_fsm_t;

    typedef struct packed {
        mcvr_host_fsm_t fsm;
        logic [4:0]     dev_addr;
        logic [7:0]     dev_wdata;
        logic [4:0]     bus_addr;
        logic [7:0]     bus_wdata;
        logic           bus_wr;
        logic           bus_rd;
        logic           txq;
        logic [7:0]     last_rdata;
        logic [2:0]     status;
        logic [2:0]     mask;
        logic [7:0]     sw_rdata;
        logic           grant;
    } mcvr_host_state_t;

    mcvr_host_state_t st_r;
    mcvr_host_state_t st_nxt;

    // Command decode, bus sequencing and software registers.
    always_comb
    begin
        logic [2:0] ev;
        ev     = 3'b000;
        st_nxt = st_r;
        st_nxt.bus_wr   = 1'b0;
        st_nxt.bus_rd   = 1'b0;
        st_nxt.grant    = 1'b0;
        st_nxt.sw_rdata = 8'h00;

        case (st_r.fsm)
            MCVR_IDLE:
            begin
                // Commands while busy are dropped; software waits for the done event.
                if (SW_WR && SW_ADDR == MCVR_H_CMD)
                begin
                    st_nxt.txq       = SW_WDATA[MCVR_CMD_TXQ];
                    st_nxt.bus_addr  = st_r.dev_addr;
                    st_nxt.bus_wdata = st_r.dev_wdata;
                    if (SW_WDATA[MCVR_CMD_WAKE])
                    begin
                        st_nxt.bus_addr  = MCVR_OFS_WAKE;
                        st_nxt.bus_wdata = MCVR_WAKE_VALUE;
                        st_nxt.bus_wr    = 1'b1;
                    end
                    else if (SW_WDATA[MCVR_CMD_TXQ])
                    begin
                        st_nxt.bus_addr = MCVR_OFS_VLAN_LO;
                        st_nxt.bus_rd   = 1'b1;
                    end
                    else
                    begin
                        st_nxt.bus_wr = SW_WDATA[MCVR_CMD_WRITE];
                        st_nxt.bus_rd = SW_WDATA[MCVR_CMD_READ] & ~SW_WDATA[MCVR_CMD_WRITE];
                    end
                    if (st_nxt.bus_wr || st_nxt.bus_rd)
                        st_nxt.fsm = MCVR_ISSUE;
                end
            end
            MCVR_ISSUE:
            begin
                if (st_r.bus_rd)
                    st_nxt.fsm = MCVR_CAPTURE;
                else
                begin
                    st_nxt.fsm = MCVR_IDLE;
                    ev[MCVR_EV_DONE] = 1'b1;
                end
            end
            MCVR_CAPTURE:
            begin
                st_nxt.fsm = MCVR_IDLE;
                ev[MCVR_EV_DONE] = 1'b1;
                if (st_r.bus_addr != MCVR_OFS_WAKE)
                    st_nxt.last_rdata = bus.rdata;
                // Queuing is refused while the device reports a full queue.
                if (st_r.txq)
                begin
                    ev[MCVR_EV_FULL]  = bus.rdata[MCVR_QFULL_BIT];
                    ev[MCVR_EV_GRANT] = ~bus.rdata[MCVR_QFULL_BIT];
                    st_nxt.grant      = ~bus.rdata[MCVR_QFULL_BIT];
                end
            end
            default: st_nxt.fsm = MCVR_IDLE;
        endcase

        // Software register writes.
        if (SW_WR && SW_ADDR == MCVR_H_ADDR)
            st_nxt.dev_addr = SW_WDATA[4:0];
        if (SW_WR && SW_ADDR == MCVR_H_WDATA)
            st_nxt.dev_wdata = SW_WDATA;
        if (SW_WR && SW_ADDR == MCVR_H_MASK)
            st_nxt.mask = SW_WDATA[2:0];

        // Reads; a status read clears it, but a same-cycle event still sets.
        if (SW_RD)
        begin
            case (SW_ADDR)
                MCVR_H_ADDR:   st_nxt.sw_rdata = {3'b000, st_r.dev_addr};
                MCVR_H_WDATA:  st_nxt.sw_rdata = st_r.dev_wdata;
                MCVR_H_RDATA:  st_nxt.sw_rdata = st_r.last_rdata;
                MCVR_H_STATUS: st_nxt.sw_rdata = {5'b00000, st_r.status};
                MCVR_H_MASK:   st_nxt.sw_rdata = {5'b00000, st_r.mask};
                default:       st_nxt.sw_rdata = 8'h00;
            endcase
            if (SW_ADDR == MCVR_H_STATUS)
                st_nxt.status = 3'b000;
        end
        st_nxt.status = st_nxt.status | ev;
    end

    // State register with synchronous reset.
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            st_r     <= '0;
            st_r.fsm <= MCVR_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign bus.addr       = st_r.bus_addr;
    assign bus.wdata      = st_r.bus_wdata;
    assign bus.wr         = st_r.bus_wr;
    assign bus.rd         = st_r.bus_rd;
    assign SW_RDATA       = st_r.sw_rdata;
    assign TX_QUEUE_GRANT = st_r.grant;
    assign IRQ            = |(st_r.status & st_r.mask);

endmodule : mcvr_host
`default_nettype wire

/* mcvr_chk.sv */
// Checker for the register bus between host and device ends.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module mcvr_chk
    import mcvr_pkg::*;
(
    // Clock, reset and bus.
    input wire logic       CLOCK,
    input wire logic       SYS_RST,
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    // Device outputs and wake input.
    input wire logic       SOFT_RESET,
    input wire logic       MAC_FULL_DUPLEX,
    input wire logic       BIG_ENDIAN,
    input wire logic       WAKE_REQUEST,
    input wire logic       DEVICE_AWAKE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    // Decoded strobes, so the wake read and byte order write properties state only their relation.
    wire logic rd_wake = rd && addr == MCVR_OFS_WAKE;
    wire logic wr_order = wr && addr == MCVR_OFS_BYTE_ORDER;

    AST_SOFT_RESET_PULSE: assert property (rd_wake |=> SOFT_RESET)
        else $error("soft reset pulse missing after read");
    AST_SOFT_RESET_CAUSE: assert property (SOFT_RESET |-> $past(rd_wake))
        else $error("soft reset pulse without read");
    AST_RESET_READ_ZERO: assert property (rd_wake |=> rdata == 8'h00)
        else $error("soft reset location read not zero");
    AST_VLAN_HI_WO: assert property (rd && addr == MCVR_OFS_VLAN_HI |=> rdata == 8'h00)
        else $error("write-only vlan register read not zero");
    AST_ORDER_WO: assert property (rd && addr == MCVR_OFS_BYTE_ORDER |=> rdata == 8'h00)
        else $error("write-only byte order read not zero");
    AST_STATUS_READ: assert property (rd && addr == MCVR_OFS_JAM_STATUS |=>
        rdata == {$past(BIG_ENDIAN), 7'h00})
        else $error("device status read wrong");
    AST_DUPLEX_READ: assert property (rd && addr == MCVR_OFS_MAC_CONFIG |=>
        rdata[0] == $past(MAC_FULL_DUPLEX))
        else $error("duplex field not the duplex used");
    AST_WAKE_SET: assert property (wr && addr == MCVR_OFS_WAKE && wdata[0] && !DEVICE_AWAKE |=>
        WAKE_REQUEST)
        else $error("wake bit not set by write");
    AST_WAKE_CLEAR: assert property (DEVICE_AWAKE |=> !WAKE_REQUEST)
        else $error("wake bit not cleared on wake");
    AST_BIG_ON: assert property (wr_order && wdata != 8'h00 |-> ##[1:2] BIG_ENDIAN)
        else $error("nonzero byte order not big-endian");
    AST_BIG_OFF: assert property (wr_order && wdata == 8'h00 |-> ##[1:2] !BIG_ENDIAN)
        else $error("zero byte order not little-endian");

    // Main scenarios reached.
    COV_SOFT_RESET: cover property (rd_wake ##1 SOFT_RESET);
    COV_WAKE: cover property (WAKE_REQUEST ##1 DEVICE_AWAKE);
    COV_BIG_READ: cover property (rd && addr == MCVR_OFS_JAM_STATUS ##1 rdata[7]);
endmodule // mcvr_chk
`default_nettype wire

/* testbench.sv */
// Self-checking bench: host and device ends joined by the register bus.
// Assumes the package, interface, both ends and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import mcvr_pkg::*;
;
    logic CLOCK = 1'b0, SYS_RST = 1'b1, SW_WR = 1'b0, SW_RD = 1'b0, IRQ, TX_QUEUE_GRANT;
    logic [2:0] SW_ADDR = 3'h0;
    logic [7:0] SW_WDATA = 8'h00, SW_RDATA, st, rv;
    logic TX_CFG_FULL_DUPLEX = 1'b1, PHY_FULL_DUPLEX = 1'b0, BACKOFF_REQ = 1'b0, FRAME_CHECK = 1'b0;
    logic FRAME_TAGGED = 1'b0, TX_QUEUE_FULL = 1'b0, TX_DONE_CLEAN = 1'b0, STOP_CMD = 1'b0;
    logic DEVICE_AWAKE = 1'b0, MAC_FULL_DUPLEX, EXT_MII_SELECT, BACK_TO_BACK_EN, BP_LEAK_ALLOW;
    logic BACKOFF_VALID, FRAME_ACCEPT, FRAME_VALID, FRAME_CFI, WAKE_REQUEST, BIG_ENDIAN, SOFT_RESET;
    logic [5:0] CONSEC_COLLISIONS = 6'h00;
    logic [3:0] COLLISION_NUM = 4'h0;
    logic [9:0] BACKOFF_RANDOM = 10'h000, BACKOFF_SLOTS;
    logic [15:0] FRAME_TPID = 16'h0000;
    logic [11:0] FRAME_VID = 12'h000;
    logic [6:0] TX_END_PAGE = 7'h00;
    logic [2:0] FRAME_PRIORITY;
    int err_count = 0, compares = 0, cycles = 0, n_grant = 0, n_soft = 0;

    mcvr_bus_if bus ();
    mcvr_host u_mcvr_host (.*, .bus(bus.host));
    mcvr_device u_mcvr_device (.*, .bus(bus.device));
    mcvr_chk u_mcvr_chk (.*, .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd),
        .rdata(bus.rdata));

    always #5 CLOCK = ~CLOCK;

    // Pulse counters and a hang guard far above the expected run length.
    always @(posedge CLOCK)
    begin
        cycles <= cycles + 1;
        n_grant <= n_grant + int'(TX_QUEUE_GRANT === 1'b1);
        n_soft <= n_soft + int'(SOFT_RESET === 1'b1);
        if (cycles == 20000)
        begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Software port strobes last one cycle; read data is taken in the cycle after.
    task automatic sw_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        SW_ADDR <= a;
        SW_WDATA <= d;
        SW_WR <= 1'b1;
        @(posedge CLOCK);
        SW_WR <= 1'b0;
    endtask

    task automatic sw_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge CLOCK);
        SW_ADDR <= a;
        SW_RD <= 1'b1;
        @(posedge CLOCK);
        SW_RD <= 1'b0;
        #1 d = SW_RDATA;
    endtask

    // One device access: status bits are gathered, since each status read clears them.
    task automatic dev(input logic [4:0] a, input logic [7:0] d, input logic [7:0] c);
        logic [7:0] s;
        sw_wr(MCVR_H_ADDR, {3'h0, a});
        sw_wr(MCVR_H_WDATA, d);
        sw_wr(MCVR_H_CMD, c);
        st = 8'h00;
        for (int i = 0; i < 20 && st[0] !== 1'b1; i++)
        begin
            sw_rd(MCVR_H_STATUS, s);
            st = st | s;
        end
        sw_rd(MCVR_H_RDATA, rv);
    endtask

    task automatic irq_case(input logic [7:0] m, input logic e);
        sw_wr(MCVR_H_MASK, m);
        sw_wr(MCVR_H_CMD, 8'h01);
        repeat (4) @(posedge CLOCK);
        #1 check("irq level", {15'h0000, e}, {15'h0000, IRQ});
        sw_rd(MCVR_H_STATUS, st);
        @(posedge CLOCK);
        #1 check("irq after clear", {st[0], 1'b0}, {1'b1, IRQ});
    endtask

    task automatic t_mac();
        logic [7:0] cfg [5] = '{8'h0C, 8'h0C, 8'h0D, 8'h01, 8'h01};
        logic [1:0] pin [5] = '{2'b10, 2'b01, 2'b00, 2'b10, 2'b01};
        logic [4:0] dup = 5'b10101;
        for (int i = 0; i < 5; i++)
        begin
            {TX_CFG_FULL_DUPLEX, PHY_FULL_DUPLEX} <= pin[i];
            dev(MCVR_OFS_MAC_CONFIG, cfg[i], 8'h01);
            check("duplex used", dup[i], MAC_FULL_DUPLEX);
            check("media and b2b", cfg[i][3:2], {EXT_MII_SELECT, BACK_TO_BACK_EN});
            dev(MCVR_OFS_MAC_CONFIG, 8'h00, 8'h02);
            check("config read", {cfg[i][7:1], dup[i]}, rv);
        end
    endtask

    task automatic leak(input logic [5:0] c, input logic e);
        @(posedge CLOCK);
        CONSEC_COLLISIONS <= c;
        repeat (2) @(posedge CLOCK);
        #1 check("leak allow", e, BP_LEAK_ALLOW);
    endtask

    task automatic boff(input logic [3:0] n, input logic [9:0] e);
        @(posedge CLOCK);
        BACKOFF_REQ <= 1'b1;
        COLLISION_NUM <= n;
        BACKOFF_RANDOM <= 10'h3FF;
        @(posedge CLOCK);
        BACKOFF_REQ <= 1'b0;
        #1 check("backoff", {1'b1, e}, {BACKOFF_VALID, BACKOFF_SLOTS});
    endtask

    task automatic frm(input logic t, input logic [15:0] p, input logic [11:0] v, input logic e);
        @(posedge CLOCK);
        FRAME_CHECK <= 1'b1;
        FRAME_TAGGED <= t;
        FRAME_TPID <= p;
        FRAME_VID <= v;
        @(posedge CLOCK);
        FRAME_CHECK <= 1'b0;
        #1 check("frame", {1'b1, e}, {FRAME_VALID, FRAME_ACCEPT});
    endtask

    task automatic txev(input logic [6:0] pg, input logic stop, input logic [7:0] e);
        @(posedge CLOCK);
        TX_DONE_CLEAN <= 1'b1;
        TX_END_PAGE <= pg;
        STOP_CMD <= stop;
        @(posedge CLOCK);
        TX_DONE_CLEAN <= 1'b0;
        STOP_CMD <= 1'b0;
        dev(MCVR_OFS_VLAN_LO, 8'h00, 8'h02);
        check("end page", e, rv);
    endtask

    // Main sequence: reset for ten cycles, then each scenario in turn.
    initial
    begin
        repeat (10) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        irq_case(8'h01, 1'b1);
        irq_case(8'h00, 1'b0);
        dev(5'h05, 8'h00, 8'h02);
        check("unmapped read", 8'h00, rv);
        check("internal phy duplex", 1'b0, MAC_FULL_DUPLEX);
        dev(MCVR_OFS_JAM_STATUS, 8'h00, 8'h02);
        check("status reset", 8'h00, rv);
        txev(7'h00, 1'b1, 8'h00);
        t_mac();
        dev(MCVR_OFS_MAC_CONFIG, 8'h00, 8'h01);
        leak(6'h19, 1'b1);
        leak(6'h18, 1'b0);
        dev(MCVR_OFS_JAM_STATUS, 8'h05, 8'h01);
        leak(6'h05, 1'b1);
        dev(MCVR_OFS_MAC_CONFIG, 8'h02, 8'h01);
        leak(6'h3F, 1'b0);
        boff(4'h4, 10'h00F);
        dev(MCVR_OFS_MAC_CONFIG, 8'h20, 8'h01);
        boff(4'h1, 10'h002);
        boff(4'h2, 10'h000);
        boff(4'h3, 10'h007);
        dev(MCVR_OFS_MAC_CONFIG, 8'h40, 8'h01);
        boff(4'h5, 10'h003);
        dev(MCVR_OFS_MAC_CONFIG, 8'h80, 8'h01);
        boff(4'hC, 10'h000);
        dev(MCVR_OFS_VLAN_LO, 8'h34, 8'h01);
        dev(MCVR_OFS_VLAN_HI, 8'hB5, 8'h01);
        check("priority cfi", 4'hB, {FRAME_PRIORITY, FRAME_CFI});
        frm(1'b0, 16'h0000, 12'h000, 1'b1);
        dev(MCVR_OFS_MAC_CONFIG, 8'h10, 8'h01);
        frm(1'b1, 16'h8100, 12'h534, 1'b1);
        frm(1'b1, 16'h8100, 12'h000, 1'b1);
        frm(1'b1, 16'h8100, 12'h434, 1'b0);
        frm(1'b0, 16'h8100, 12'h534, 1'b0);
        frm(1'b1, 16'h88A8, 12'h123, 1'b1);
        txev(7'h40, 1'b0, 8'h40);
        TX_QUEUE_FULL <= 1'b1;
        txev(7'h7F, 1'b0, 8'hFF);
        dev(5'h00, 8'h00, 8'h04);
        check("queue refused", 3'b011, st[2:0]);
        check("no grant", 0, n_grant);
        TX_QUEUE_FULL <= 1'b0;
        dev(5'h00, 8'h00, 8'h04);
        check("queue granted", 3'b101, st[2:0]);
        check("grant count", 1, n_grant);
        txev(7'h55, 1'b1, 8'h00);
        dev(MCVR_OFS_BYTE_ORDER, 8'h01, 8'h01);
        dev(MCVR_OFS_JAM_STATUS, 8'h00, 8'h02);
        check("big endian", 9'h180, {BIG_ENDIAN, rv});
        dev(MCVR_OFS_BYTE_ORDER, 8'h00, 8'h01);
        check("little endian", 1'b0, BIG_ENDIAN);
        dev(5'h00, 8'h00, 8'h08);
        check("wake request", 1'b1, WAKE_REQUEST);
        @(posedge CLOCK);
        DEVICE_AWAKE <= 1'b1;
        @(posedge CLOCK);
        DEVICE_AWAKE <= 1'b0;
        #1 check("wake cleared", 1'b0, WAKE_REQUEST);
        dev(MCVR_OFS_WAKE, 8'h00, 8'h02);
        check("soft reset pulses", 16'(1), 16'(n_soft));
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
